//--- core/pm_device.sv
/*
 Power monitor slave end: bit level engine on the link clock SCL, command
 and result registers on the system clock, toggle handshakes between them.
 Assumes the converter side pulses v_done / i_done with a stable code and
 that the master keeps SDA changes inside SCL low phases.
*/
`timescale 1ns/10ps
module pm_device
(
	input logic clock,
	input logic sys_rst,
	input logic [1:0] strap_state,
	pm_if.device link,
	input logic v_done,
	input logic [11:0] v_code,
	input logic i_done,
	input logic [11:0] i_code,
	input logic [7:0] alert_status,
	output logic voltage_repeat_convert,
	output logic current_repeat_convert,
	output logic divider_scale_select,
	output logic status_select,
	output logic v_once_req,
	output logic i_once_req
);
	typedef enum logic [5:0]
	{
		S_IDLE = 6'h01,
		S_ADDR = 6'h02,
		S_ACKA = 6'h04,
		S_WR = 6'h08,
		S_ACKW = 6'h10,
		S_RD = 6'h20
	} pm_dst_e;

	// System clock side
	logic [1:0] strap_s1_r, strap_s2_r, strap_r, strap_cnt_r;
	logic ct_s1_r, ct_s2_r, ct_seen_r;
	logic ak_s1_r, ak_s2_r;
	logic [11:0] vres_r, ires_r;
	logic v_pend_r, i_pend_r;
	logic [11:0] snap_v_r, snap_i_r;
	logic [7:0] snap_st_r;
	logic snap_busy_r, snap_ct_r, snap_tog_r;
	// Link clock side
	logic start_tog_r, start_seen_r;
	pm_dst_e st_r;
	logic mack_r;
	logic [2:0] bit_r;
	logic [7:0] sh_r, tx_r;
	logic rw_r, first_r;
	logic [1:0] idx_r;
	logic [6:0] cmd_r;
	logic cmd_tog_r;
	logic [1:0] adr_s1_r, adr_s2_r;
	logic pb_s1_r, pb_s2_r, ack_tog_r;
	logic [11:0] rv_r, ri_r;
	logic [7:0] rst_r;
	logic rbusy_r, rct_r;
	logic oe_r;

	wire cmd_new = ct_s2_r ^ ct_seen_r;
	wire snap_free = ak_s2_r == snap_tog_r;

	// Strap caught a few cycles after release, then frozen
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
			strap_r <= 2'h0;
			strap_cnt_r <= 2'h0;
		end
		else
		begin
			strap_s1_r <= strap_state;
			strap_s2_r <= strap_s1_r;
			if (strap_cnt_r != 2'(pm_pkg::STRAP_SETTLE))
			begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
				strap_r <= strap_s2_r;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ct_s1_r <= 1'b0;
			ct_s2_r <= 1'b0;
			ct_seen_r <= 1'b0;
			voltage_repeat_convert <= 1'b0;
			current_repeat_convert <= 1'b0;
			divider_scale_select <= 1'b0;
			status_select <= 1'b0;
			v_once_req <= 1'b0;
			i_once_req <= 1'b0;
		end
		else
		begin
			ct_s1_r <= cmd_tog_r;
			ct_s2_r <= ct_s1_r;
			ct_seen_r <= ct_s2_r;
			v_once_req <= cmd_new & cmd_r[pm_pkg::CMD_V_ONCE];
			i_once_req <= cmd_new & cmd_r[pm_pkg::CMD_I_ONCE];
			if (cmd_new)
			begin
				voltage_repeat_convert <= cmd_r[pm_pkg::CMD_VOLTAGE_REPEAT_CONVERT];
				current_repeat_convert <= cmd_r[pm_pkg::CMD_CURRENT_REPEAT_CONVERT];
				divider_scale_select <= cmd_r[pm_pkg::CMD_RANGE];
				status_select <= cmd_r[pm_pkg::CMD_STATUS];
			end
		end
	end

	// results zeroed by a command, one-shots pend
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			vres_r <= 12'h000;
			ires_r <= 12'h000;
			v_pend_r <= 1'b0;
			i_pend_r <= 1'b0;
		end
		else if (cmd_new)
		begin
			vres_r <= 12'h000;
			ires_r <= 12'h000;
			v_pend_r <= cmd_r[pm_pkg::CMD_V_ONCE];
			i_pend_r <= cmd_r[pm_pkg::CMD_I_ONCE];
		end
		else
		begin
			if (v_done)
			begin
				vres_r <= v_code;
				v_pend_r <= 1'b0;
			end
			if (i_done)
			begin
				ires_r <= i_code;
				i_pend_r <= 1'b0;
			end
		end
	end

	// Snapshot only reloads after the link side took the last one
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ak_s1_r <= 1'b0;
			ak_s2_r <= 1'b0;
			snap_v_r <= 12'h000;
			snap_i_r <= 12'h000;
			snap_st_r <= 8'h00;
			snap_busy_r <= 1'b0;
			snap_ct_r <= 1'b0;
			snap_tog_r <= 1'b0;
		end
		else
		begin
			ak_s1_r <= ack_tog_r;
			ak_s2_r <= ak_s1_r;
			if (snap_free)
			begin
				snap_v_r <= vres_r;
				snap_i_r <= ires_r;
				snap_st_r <= alert_status;
				snap_busy_r <= v_pend_r | i_pend_r;
				snap_ct_r <= ct_seen_r;
				snap_tog_r <= ~snap_tog_r;
			end
		end
	end

	// Start: SDA falls while SCL high
	always_ff @(negedge link.sda or posedge sys_rst)
	begin
		if (sys_rst)
			start_tog_r <= 1'b0;
		else if (link.scl)
			start_tog_r <= ~start_tog_r;
	end

	wire frame_go = start_tog_r ^ start_seen_r;
	wire [7:0] sh_nxt = {sh_r[6:0], link.sda};
	wire last_bit = bit_r == 3'h7;
	// address from fixed bits and strap
	wire adr_hit = sh_nxt[7:1] == {pm_pkg::ADDR_HI, adr_s2_r};
	wire v_sel = cmd_r[pm_pkg::CMD_VOLTAGE_REPEAT_CONVERT] | cmd_r[pm_pkg::CMD_V_ONCE];
	wire i_sel = cmd_r[pm_pkg::CMD_CURRENT_REPEAT_CONVERT] | cmd_r[pm_pkg::CMD_I_ONCE];
	wire st_sel = cmd_r[pm_pkg::CMD_STATUS];
	wire once_cmd = cmd_r[pm_pkg::CMD_V_ONCE] | cmd_r[pm_pkg::CMD_I_ONCE];
	// Busy until the snapshot reflects our latest one-shot command
	wire busy_l = rbusy_r | ((cmd_tog_r ^ rct_r) & once_cmd);
	wire frozen = (st_r == S_ACKA) | (st_r == S_RD) | mack_r;
	wire [1:0] nbytes = st_sel ? 2'h1 : ((v_sel & i_sel) ? 2'h3 : 2'h2);
	wire [1:0] pick = (st_r == S_ACKA) ? 2'h0 : idx_r;
	wire [1:0] pick_inc = pick + 2'h1;
	wire [1:0] idx_nxt = (pick_inc == nbytes) ? 2'h0 : pick_inc;
	wire [7:0] b_both = (pick == 2'h0) ? rv_r[11:4] :
		((pick == 2'h1) ? ri_r[11:4] : {rv_r[3:0], ri_r[3:0]});
	wire [11:0] one_res = (i_sel & !v_sel) ? ri_r : rv_r;
	wire [7:0] b_one = (pick == 2'h0) ? one_res[11:4] : {one_res[3:0], 4'h0};
	wire [7:0] tx_pick = st_sel ? rst_r : ((v_sel & i_sel) ? b_both : b_one);

	always_ff @(posedge link.scl or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			adr_s1_r <= 2'h0;
			adr_s2_r <= 2'h0;
			pb_s1_r <= 1'b0;
			pb_s2_r <= 1'b0;
			ack_tog_r <= 1'b0;
			rv_r <= 12'h000;
			ri_r <= 12'h000;
			rst_r <= 8'h00;
			rbusy_r <= 1'b0;
			rct_r <= 1'b0;
		end
		else
		begin
			adr_s1_r <= strap_r;
			adr_s2_r <= adr_s1_r;
			pb_s1_r <= snap_tog_r;
			pb_s2_r <= pb_s1_r;
			// Result words held still across one read
			if ((pb_s2_r != ack_tog_r) && !frozen)
			begin
				rv_r <= snap_v_r;
				ri_r <= snap_i_r;
				rst_r <= snap_st_r;
				rbusy_r <= snap_busy_r;
				rct_r <= snap_ct_r;
				ack_tog_r <= pb_s2_r;
			end
		end
	end

	always_ff @(posedge link.scl or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			start_seen_r <= 1'b0;
			st_r <= S_IDLE;
			mack_r <= 1'b0;
			bit_r <= 3'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			first_r <= 1'b0;
			idx_r <= 2'h0;
			cmd_r <= pm_pkg::CMD_RESET;
			cmd_tog_r <= 1'b0;
		end
		else if (frame_go)
		begin
			// first bit after start is address MSB
			start_seen_r <= start_tog_r;
			st_r <= S_ADDR;
			mack_r <= 1'b0;
			bit_r <= 3'h1;
			sh_r <= sh_nxt;
		end
		else
		begin
			sh_r <= sh_nxt;
			bit_r <= bit_r + 3'h1;
			if (mack_r)
			begin
				bit_r <= 3'h0;
				mack_r <= 1'b0;
				st_r <= link.sda ? S_IDLE : S_RD;
				tx_r <= tx_pick;
				idx_r <= idx_nxt;
			end
			else
			begin
				case (st_r)
					S_IDLE:
						bit_r <= 3'h0;
					S_ADDR:
						if (last_bit)
						begin
							st_r <= adr_hit ? S_ACKA : S_IDLE;
							rw_r <= sh_nxt[0];
						end
					S_ACKA:
					begin
						bit_r <= 3'h0;
						first_r <= 1'b1;
						tx_r <= tx_pick;
						idx_r <= idx_nxt;
						if (rw_r)
							st_r <= busy_l ? S_IDLE : S_RD;
						else
							st_r <= S_WR;
					end
					S_WR:
						if (last_bit)
							st_r <= S_ACKW;
					S_ACKW:
					begin
						bit_r <= 3'h0;
						first_r <= 1'b0;
						st_r <= S_WR;
						// command byte commits at its ack
						if (first_r && !sh_r[pm_pkg::CMD_EXT])
						begin
							cmd_r <= sh_r[6:0];
							cmd_tog_r <= ~cmd_tog_r;
						end
					end
					S_RD:
						if (last_bit)
							mack_r <= 1'b1;
					default:
						st_r <= S_IDLE;
				endcase
			end
		end
	end

	// drive changes only while SCL is low, on its falling edge
	wire ack_a = (st_r == S_ACKA) && !(rw_r && busy_l);
	wire tx_low = (st_r == S_RD) && !mack_r && !tx_r[3'h7 - bit_r];
	wire oe_nxt = ack_a | ((st_r == S_ACKW) && !mack_r) | tx_low;

	always_ff @(negedge link.scl or posedge sys_rst)
	begin
		if (sys_rst)
			oe_r <= 1'b0;
		else
			oe_r <= oe_nxt;
	end

	assign link.sda_s_oe = oe_r;
endmodule : pm_device

//--- core/pm_pkg.sv
/*
 Shared constants for the power monitor two-wire command port: slave
 address, command byte fields, request kinds and bit timing.
 Assumes both ends are compiled after this package.
*/
package pm_pkg;
	// Fixed upper address bits 10110
	localparam logic [4:0] ADDR_HI = 5'h16;
	// Strap states give the low address bits (0xB0, 0xB2, 0xB4, 0xB6)
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_RES = 2'h1;
	localparam logic [1:0] STRAP_FLOAT = 2'h2;
	localparam logic [1:0] STRAP_HIGH = 2'h3;
	// Command byte field positions
	localparam int CMD_VOLTAGE_REPEAT_CONVERT = 0;
	localparam int CMD_V_ONCE = 1;
	localparam int CMD_CURRENT_REPEAT_CONVERT = 2;
	localparam int CMD_I_ONCE = 3;
	localparam int CMD_RANGE = 4;
	localparam int CMD_STATUS = 6;
	localparam int CMD_EXT = 7;
	localparam logic [6:0] CMD_RESET = 7'h00;
	// Host request kinds
	localparam logic [1:0] REQ_QUICK = 2'h0;
	localparam logic [1:0] REQ_WRITE = 2'h1;
	localparam logic [1:0] REQ_READ = 2'h2;
	// Fast mode bit period and system clock period
	localparam int SCL_PERIOD_NS = 2500;
	localparam int CLK_PERIOD_NS = 10;
	// Quarter bit, least time so rounded up
	localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
	localparam int STRAP_SETTLE = 3;
endpackage : pm_pkg

//--- core/pm_if.sv
/*
 Two-wire link between the bus master and the power monitor.
 SDA is open drain: either end pulling low makes the line low.
 SCL is driven only by the master; the slave never stretches it.
*/
`timescale 1ns/10ps
interface pm_if;
	logic scl;
	logic sda;
	logic sda_m_oe;
	logic sda_s_oe;
	assign sda = !(sda_m_oe | sda_s_oe);
	modport device
	(
		input scl,
		input sda,
		output sda_s_oe
	);
	modport host
	(
		output scl,
		input sda,
		output sda_m_oe
	);
endinterface : pm_if

//--- core/pm_host.sv
/*
 Bus master end: makes SCL from the system clock by a quarter-bit divider
 and runs quick, command write and result read transfers on request.
 Assumes the slave never stretches SCL.
*/
`timescale 1ns/10ps
module pm_host
#(
	parameter int QTR = pm_pkg::QTR_CYCLES
)
(
	input logic clock,
	input logic sys_rst,
	pm_if.host link,
	input logic req_valid,
	input logic [1:0] req_kind,
	input logic [6:0] req_addr,
	input logic [7:0] req_wdata,
	input logic [1:0] req_rlen,
	output logic req_busy,
	output logic done,
	output logic nack,
	output logic [23:0] rdata
);
	typedef enum logic [3:0]
	{
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BIT = 4'h4,
		H_STOP = 4'h8
	} pm_hst_e;

	pm_hst_e st_r;
	logic [7:0] q_cnt_r;
	logic [1:0] ph_r;
	logic [3:0] bitn_r;
	logic [1:0] byten_r, total_r, kind_r;
	logic [7:0] sh_r, wdata_r;
	logic scl_r, oe_r, nk_r;
	logic sda_s1_r, sda_s2_r;

	wire tick = q_cnt_r == 8'(QTR - 1);
	wire tx_byte = (byten_r == 2'h0) || (kind_r == pm_pkg::REQ_WRITE);
	wire last_byte = byten_r == total_r;
	wire ack_slot = bitn_r == 4'h8;
	wire [1:0] total_in = (req_kind == pm_pkg::REQ_READ) ? req_rlen :
		((req_kind == pm_pkg::REQ_WRITE) ? 2'h1 : 2'h0);
	wire bit_drive = ack_slot ? (!tx_byte && !last_byte) : (tx_byte && !sh_r[7]);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			q_cnt_r <= 8'h00;
		end
		else
		begin
			sda_s1_r <= link.sda;
			sda_s2_r <= sda_s1_r;
			q_cnt_r <= (tick || st_r == H_IDLE) ? 8'h00 : q_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= H_IDLE;
			ph_r <= 2'h0;
			bitn_r <= 4'h0;
			byten_r <= 2'h0;
			total_r <= 2'h0;
			kind_r <= 2'h0;
			sh_r <= 8'h00;
			wdata_r <= 8'h00;
			scl_r <= 1'b1;
			oe_r <= 1'b0;
			nk_r <= 1'b0;
			req_busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			rdata <= 24'h00_0000;
		end
		else
		begin
			done <= 1'b0;
			if (tick)
				ph_r <= ph_r + 2'h1;
			case (st_r)
				H_IDLE:
				begin
					ph_r <= 2'h0;
					if (req_valid)
					begin
						st_r <= H_START;
						req_busy <= 1'b1;
						nack <= 1'b0;
						rdata <= 24'h00_0000;
						kind_r <= req_kind;
						total_r <= total_in;
						wdata_r <= req_wdata;
						sh_r <= {req_addr, req_kind == pm_pkg::REQ_READ};
					end
				end
				H_START:
					if (tick)
					begin
						if (ph_r == 2'h2)
							oe_r <= 1'b1;
						if (ph_r == 2'h3)
						begin
							scl_r <= 1'b0;
							st_r <= H_BIT;
							bitn_r <= 4'h0;
							byten_r <= 2'h0;
						end
					end
				H_BIT:
					if (tick)
					begin
						// data changes a quarter after SCL falls
						if (ph_r == 2'h0)
							oe_r <= bit_drive;
						if (ph_r == 2'h1)
							scl_r <= 1'b1;
						if (ph_r == 2'h2)
						begin
							if (ack_slot)
								nk_r <= tx_byte & sda_s2_r;
							else if (tx_byte)
								sh_r <= {sh_r[6:0], 1'b0};
							else
								rdata <= {rdata[22:0], sda_s2_r};
						end
						if (ph_r == 2'h3)
						begin
							scl_r <= 1'b0;
							bitn_r <= bitn_r + 4'h1;
							if (ack_slot)
							begin
								bitn_r <= 4'h0;
								byten_r <= byten_r + 2'h1;
								sh_r <= wdata_r;
								nack <= nk_r;
								// stop after last or refused byte
								if (nk_r || last_byte)
									st_r <= H_STOP;
							end
						end
					end
				H_STOP:
					if (tick)
					begin
						if (ph_r == 2'h0)
							oe_r <= 1'b1;
						if (ph_r == 2'h1)
							scl_r <= 1'b1;
						if (ph_r == 2'h2)
							oe_r <= 1'b0;
						if (ph_r == 2'h3)
						begin
							st_r <= H_IDLE;
							req_busy <= 1'b0;
							done <= 1'b1;
						end
					end
				default:
					st_r <= H_IDLE;
			endcase
		end
	end

	// master owns SCL, quarter-bit divider gives fast mode
	assign link.scl = scl_r;
	assign link.sda_m_oe = oe_r;
endmodule : pm_host

//--- test/pm_link_props.sv
/*
 Wire checker for the power monitor two-wire link: SCL, SDA and the device pull-down enable sda_s_oe.
 Assumes the host makes SCL with a quarter-bit of QTR system clocks.
*/
`timescale 1ns/10ps
module pm_link_props
#(
	parameter int QTR = 4
)
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [1:0] strap_state,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe
);
	logic scl_r;
	logic sda_r;
	logic frame_r;
	logic [6:0] nbit_r;
	logic [7:0] addr_r;
	logic [7:0] gap_r;
	wire rise_w = scl && !scl_r;
	wire start_w = scl && scl_r && sda_r && !sda;
	wire stop_w = scl && scl_r && !sda_r && sda;
	wire rw_w = addr_r[0];
	wire match_w = addr_r[7:1] == {pm_pkg::ADDR_HI, strap_state};
	wire slot_w = (nbit_r % 9) == 8;

	// Gap saturates so the first edge after reset never looks fast
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			frame_r <= 1'b0;
			nbit_r <= 7'h00;
			addr_r <= 8'h00;
			gap_r <= 8'hff;
		end
		else
		begin
			scl_r <= scl;
			sda_r <= sda;
			gap_r <= rise_w ? 8'h01 : ((gap_r == 8'hff) ? gap_r : gap_r + 8'h01);
			if (start_w)
			begin
				frame_r <= 1'b1;
				nbit_r <= 7'h00;
			end
			else if (stop_w)
				frame_r <= 1'b0;
			else if (rise_w && frame_r)
			begin
				nbit_r <= nbit_r + 7'h01;
				if (nbit_r < 7'h08)
					addr_r <= {addr_r[6:0], sda};
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence bit_edge;
		frame_r && rise_w;
	endsequence
	sequence ack_edge;
		frame_r && rise_w && nbit_r > 7'h08 && slot_w;
	endsequence

	a_oe_low_change: assert property (
		$changed(sda_s_oe) |-> !scl) else $error("device SDA moved with SCL high");
	a_data_held: assert property (
		bit_edge |-> $stable(sda)[*3]) else $error("SDA moved during SCL high");
	a_addr_quiet: assert property (
		frame_r && nbit_r < 7'h08 |-> !sda_s_oe) else $error("device drove address bits");
	a_addr_ack: assert property (
		bit_edge and (nbit_r == 7'h08 && !rw_w) |-> sda_s_oe == match_w)
		else $error("address ack wrong");
	a_idle_other: assert property (
		frame_r && nbit_r >= 7'h08 && !match_w |-> !sda_s_oe) else $error("unaddressed drive");
	a_write_acks: assert property (
		ack_edge and (!rw_w && match_w) |-> sda_s_oe) else $error("write byte not acked");
	a_write_quiet: assert property (
		bit_edge and (nbit_r > 7'h08 && !slot_w && !rw_w) |-> !sda_s_oe)
		else $error("device drove write data");
	a_read_release: assert property (
		ack_edge and rw_w |-> !sda_s_oe) else $error("device held read ack slot");
	a_fast_rate: assert property (
		rise_w |-> gap_r >= 4 * QTR) else $error("SCL period too short");
endmodule : pm_link_props

//--- test/power_monitor_i2c_command_port_tb.sv
/*
 Bench for the power monitor link: host and device joined by the interface,
 a reference model of the command port, and the wire checker beside them.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module power_monitor_i2c_command_port_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] strap_state = 2'h0;
	logic v_done = 1'b0;
	logic [11:0] v_code = 12'h000;
	logic i_done = 1'b0;
	logic [11:0] i_code = 12'h000;
	logic [7:0] alert_status = 8'h00;
	logic req_valid = 1'b0;
	logic [1:0] req_kind = 2'h0;
	logic [6:0] req_addr = 7'h00;
	logic [7:0] req_wdata = 8'h00;
	logic [1:0] req_rlen = 2'h0;
	logic req_busy, done, nack, v_rep, i_rep, rng, stat, v_once, i_once;
	logic [23:0] rdata;
	logic [6:0] cfg, adr;
	logic [11:0] v_res, i_res;
	logic v_pend, i_pend;
	int n_errors = 0;
	int cmp_count = 0;
	int n_vo = 0;
	int n_io = 0;
	pm_if link ();
	always #5 clock = ~clock;
	pm_device i_pm_device (.clock(clock), .sys_rst(sys_rst), .strap_state(strap_state),
		.link(link), .v_done(v_done), .v_code(v_code), .i_done(i_done), .i_code(i_code),
		.alert_status(alert_status), .voltage_repeat_convert(v_rep),
		.current_repeat_convert(i_rep), .divider_scale_select(rng), .status_select(stat),
		.v_once_req(v_once), .i_once_req(i_once));
	pm_host #(.QTR(4)) i_pm_host (.clock(clock), .sys_rst(sys_rst), .link(link),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_rlen(req_rlen), .req_busy(req_busy), .done(done),
		.nack(nack), .rdata(rdata));
	pm_link_props #(.QTR(4)) i_pm_link_props (.clock(clock), .sys_rst(sys_rst),
		.strap_state(strap_state), .scl(link.scl), .sda(link.sda),
		.sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));
	always @(posedge clock)
	begin
		n_vo <= n_vo + v_once;
		n_io <= n_io + i_once;
	end

	task automatic req(input logic [1:0] k, input logic [6:0] a, input logic [7:0] w,
		input logic [1:0] n);
		@(posedge clock);
		#1;
		req_valid = 1'b1;
		req_kind = k;
		req_addr = a;
		req_wdata = w;
		req_rlen = n;
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		`CHK(req_busy, 1'b1) // Request taken
		for (int t = 0; t < 5000 && done !== 1'b1; t++)
		begin
			@(posedge clock);
			#1;
		end
		// A hung transfer ends the run as a failure
		if (done !== 1'b1)
		begin
			n_errors++;
			finish_test();
		end
		`CHK(req_busy, 1'b0) // Idle at done
	endtask : req

	task automatic boot(input logic [1:0] s);
		strap_state = s;
		sys_rst = 1'b1;
		repeat (10) @(posedge clock);
		#1;
		sys_rst = 1'b0;
		repeat (12) @(posedge clock);
		#1;
		adr = {pm_pkg::ADDR_HI, s};
		cfg = 7'h00;
		{v_res, i_res, v_pend, i_pend} = '0;
	endtask : boot

	task automatic cmd(input logic [7:0] c);
		int nv0;
		int ni0;
		nv0 = n_vo;
		ni0 = n_io;
		req(pm_pkg::REQ_WRITE, adr, c, 2'h0);
		`CHK(nack, 1'b0) // Byte acked
		if (!c[7])
		begin
			cfg = c[6:0];
			{v_res, i_res} = '0;
			v_pend = c[1];
			i_pend = c[3];
		end
		repeat (6) @(posedge clock);
		#1;
		`CHK({stat, rng, i_rep, v_rep}, {cfg[6], cfg[4], cfg[2], cfg[0]}) // Levels
		`CHK(n_vo - nv0 + 2 * (n_io - ni0), {c[3], c[1]} & {2{!c[7]}}) // One pulse
	endtask : cmd

	task automatic conv(input logic dv, input logic di);
		v_code = 12'($urandom);
		i_code = 12'($urandom);
		v_done = dv;
		i_done = di;
		@(posedge clock);
		#1;
		v_done = 1'b0;
		i_done = 1'b0;
		if (dv)
			{v_res, v_pend} = {v_code, 1'b0};
		if (di)
			{i_res, i_pend} = {i_code, 1'b0};
	endtask : conv

	task automatic rd();
		logic [1:0] n;
		logic [23:0] m;
		logic [23:0] e;
		logic both;
		both = (cfg[0] | cfg[1]) && (cfg[2] | cfg[3]);
		n = cfg[6] ? 2'h1 : (both ? 2'h3 : 2'h2);
		m = 24'hff_ffff >> (8 * (3 - n));
		if (cfg[6])
			e = {16'h0000, alert_status};
		else if (both)
			e = {v_res[11:4], i_res[11:4], v_res[3:0], i_res[3:0]};
		else
			e = {8'h00, (cfg[2] | cfg[3]) ? i_res : v_res, 4'h0};
		// Quick frame first lets fresh results reach the link side
		req(pm_pkg::REQ_QUICK, adr, 8'h00, 2'h0);
		req(pm_pkg::REQ_READ, adr, 8'h00, n);
		`CHK(nack, v_pend | i_pend) // Refusal
		`CHK(rdata & m, (v_pend | i_pend) ? 24'h0 : e & m) // Layout
		$display("test read of %0d bytes done", n);
	endtask : rd

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	initial
	begin
		void'($urandom(32'h9275_876b));
		alert_status = 8'($urandom);
		for (int s = 0; s < 4; s++)
		begin
			boot(2'(s));
			`CHK({v_rep, i_rep, rng, stat}, 4'h0) // Defaults
			req(pm_pkg::REQ_QUICK, adr, 8'h00, 2'h0);
			`CHK(nack, 1'b0) // Own address
			req(pm_pkg::REQ_QUICK, {adr[6:2], adr[1:0] + 2'h1}, 8'h00, 2'h0);
			`CHK(nack, 1'b1) // Other address
			$display("test strap %0d done", s);
		end
		rd();
		cmd(8'h05);
		rd();
		conv(1'b1, 1'b1);
		rd();
		cmd(8'h14);
		conv(1'b0, 1'b1);
		rd();
		cmd(8'h0a);
		rd();
		conv(1'b1, 1'b1);
		rd();
		cmd(8'h08);
		rd();
		conv(1'b0, 1'b1);
		rd();
		cmd(8'h60);
		rd();
		cmd(8'h85);
		rd();
		repeat (4)
		begin
			cmd({1'b0, 7'($urandom)});
			conv(1'b1, 1'b1);
			rd();
		end
		finish_test();
	end

	initial
	begin
		#900_000;
		n_errors++;
		finish_test();
	end
endmodule : power_monitor_i2c_command_port_tb
